// ### logic/sfp_regs.svh
// Opcodes, pin indices, reset levels and protection region codes.
// Assumes inclusion by bare name from the hold/protect block.
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH
// Instruction opcodes
`define SFP_OP_STATUS_WRITE_CMD 8'h01
`define SFP_OP_WRITE_DISABLE_CMD 8'h04
`define SFP_OP_RDSR 8'h05
`define SFP_OP_WRITE_ENABLE_CMD 8'h06
// Bit counter values
`define SFP_CNT_ZERO 3'h0
`define SFP_CNT_LAST 3'h7
`define SFP_CNT_ONE 3'h1
// Synchronised pin indices and their reset levels
`define SFP_PIN_SCK 0
`define SFP_PIN_SI 1
`define SFP_PIN_SEL 2
`define SFP_PIN_HOLD 3
`define SFP_PIN_WP 4
`define SFP_PIN_RST 5'h1C
// Status byte field positions
`define SFP_ST_LOCK 7
`define SFP_ST_BOT 5
`define SFP_ST_HI 4
`define SFP_ST_MID 3
`define SFP_ST_LO 2
// Protection level codes and region tags
`define SFP_LVL_EIGHTH 2'h1
`define SFP_LVL_QUARTER 2'h2
`define SFP_LVL_HALF 2'h3
`define SFP_TOP_EIGHTH 3'h7
`define SFP_TOP_QUARTER 2'h3
`define SFP_TOP_HALF 1'h1
`endif

// ### logic/sfp_pkg.sv
// Types shared by the hold/protect block and its bench.
// Assumes a 512-Kbyte array addressed by 19 bits.
package sfp_pkg;
    // Serial sequence states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_OPC = 5'h02,
        ST_WDATA = 5'h04,
        ST_RDSR = 5'h08,
        ST_SKIP = 5'h10
    } sfp_state_e;
    // Status byte as read out
    typedef struct packed {
        logic lock;
        logic spare;
        logic bottom;
        logic lvl_hi;
        logic lvl_mid;
        logic lvl_lo;
        logic write_latch;
        logic busy;
    } sfp_status_s;
    // Non-volatile protection bits
    typedef struct packed {
        logic lock;
        logic bottom;
        logic lvl_hi;
        logic lvl_mid;
        logic lvl_lo;
    } sfp_prot_s;
    // Program and erase kinds
    typedef enum logic [1:0] {
        PE_PAGE = 2'h0,
        PE_SECTOR = 2'h1,
        PE_BLOCK = 2'h2,
        PE_CHIP = 2'h3
    } sfp_pe_e;
    // Program or erase request from the array engine
    typedef struct packed {
        sfp_pe_e kind;
        logic [18:0] addr;
    } sfp_pe_s;
endpackage : sfp_pkg

// ### logic/sfp_hold_protect.sv
// Serial flash pause logic, status register and write protection.
// Assumes pins arrive unsynchronised; the program/erase engine
// shares i_clk and keeps non-volatile bits outside this block.
`include "sfp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sfp_hold_protect
    import sfp_pkg::*;
#(
    parameter int ADDR_W = 19
) (
    input wire logic i_clk, // 50 MHz clock
    input wire logic i_rst, // Synchronous reset, high
    input wire logic i_sel_n, // Chip select pin, low
    input wire logic i_sck, // Serial clock pin
    input wire logic i_si, // Serial data in pin
    input wire logic i_hold_n, // Pause pin, low
    input wire logic i_wp_n, // Lock enable pin, low
    output logic o_so, // Serial data out
    output logic o_so_oe_n, // Data out enable, low
    output logic o_held, // Pause active
    output sfp_status_s o_status, // Status byte
    input wire sfp_prot_s i_nv_prot, // Stored bits at power-up
    output sfp_prot_s o_nv_prot, // Bits to store
    output logic o_nv_wr, // Store strobe
    input wire logic i_pe_req, // Program/erase request
    input wire sfp_pe_s i_pe, // Request kind and address
    input wire logic i_pe_done, // Engine finished
    output logic o_pe_go, // Request accepted
    output logic o_pe_refuse // Request refused
);

    // ************************************************
    // Pin synchronisers
    // ************************************************
    localparam logic [4:0] PIN_RST = `SFP_PIN_RST;
    logic [4:0] pins; // Raw pins
    wire logic [4:0] filt; // Agreed levels
    assign pins = {i_wp_n, i_hold_n, i_sel_n, i_si, i_sck};

    // Three stages; a level counts once stages two and three agree
    for (genvar g = 0; g < 5; g++) begin : g_sync
        logic [2:0] s_r; // Stage chain
        logic [2:0] s_nxt;
        logic f_r; // Filtered level
        logic f_nxt;
        always_comb begin
            s_nxt = {s_r[1:0], pins[g]};
            f_nxt = (s_r[1] == s_r[2]) ? s_r[2] : f_r;
        end
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                s_r <= {3{PIN_RST[g]}};
                f_r <= PIN_RST[g];
            end else begin
                s_r <= s_nxt;
                f_r <= f_nxt;
            end
        end
        assign filt[g] = f_r;
    end

    // ************************************************
    // State and edges
    // ************************************************
    sfp_state_e state_r, state_nxt; // Sequence state
    logic [2:0] cnt_r, cnt_nxt; // Bit count in byte
    logic [7:0] shreg_r, shreg_nxt; // Input shifter
    logic [7:0] opc_r, opc_nxt; // Latched opcode
    logic [2:0] bit_r, bit_nxt; // Output bit index
    logic so_r, so_nxt;
    logic oe_n_r, oe_n_nxt;
    logic held_r, held_nxt; // Paused
    logic busy_r, busy_nxt;
    logic wel_r, wel_nxt; // Write latch
    sfp_prot_s prot_r, prot_nxt;
    logic nv_wr_r, nv_wr_nxt;
    logic go_r, go_nxt;
    logic ref_r, ref_nxt;
    logic [4:0] prev_r; // Last filtered levels
    sfp_status_s st; // Live status byte
    logic sck_rise, sck_fall, sel_rise, sel_fall;
    logic hold_rise, hold_fall, sck_lo, prot_hit;

    assign sck_rise = filt[`SFP_PIN_SCK] & ~prev_r[`SFP_PIN_SCK];
    assign sck_fall = ~filt[`SFP_PIN_SCK] & prev_r[`SFP_PIN_SCK];
    assign sel_rise = filt[`SFP_PIN_SEL] & ~prev_r[`SFP_PIN_SEL];
    assign sel_fall = ~filt[`SFP_PIN_SEL] & prev_r[`SFP_PIN_SEL];
    assign hold_rise = filt[`SFP_PIN_HOLD] & ~prev_r[`SFP_PIN_HOLD];
    assign hold_fall = ~filt[`SFP_PIN_HOLD] & prev_r[`SFP_PIN_HOLD];
    assign sck_lo = ~filt[`SFP_PIN_SCK];

    always_comb begin
        st = '0;
        st.lock = prot_r.lock;
        st.bottom = prot_r.bottom;
        st.lvl_hi = prot_r.lvl_hi;
        st.lvl_mid = prot_r.lvl_mid;
        st.lvl_lo = prot_r.lvl_lo;
        st.write_latch = wel_r;
        st.busy = busy_r;
    end

    // ************************************************
    // Protection check
    // ************************************************
    // True when the request touches a protected area
    function automatic logic f_hit(sfp_prot_s p, sfp_pe_s r);
        logic h;
        h = 1'b0;
        if (r.kind == PE_CHIP) begin
            h = p.bottom | p.lvl_hi | p.lvl_mid | p.lvl_lo;
        end else if (p.lvl_hi) begin
            h = 1'b1;
        end else begin
            case ({p.lvl_mid, p.lvl_lo})
                `SFP_LVL_EIGHTH: h = p.bottom ? (r.addr[ADDR_W-1 -: 3] == '0)
                    : (r.addr[ADDR_W-1 -: 3] == `SFP_TOP_EIGHTH);
                `SFP_LVL_QUARTER: h = p.bottom ? (r.addr[ADDR_W-1 -: 2] == '0)
                    : (r.addr[ADDR_W-1 -: 2] == `SFP_TOP_QUARTER);
                `SFP_LVL_HALF: h = p.bottom ? (r.addr[ADDR_W-1] == 1'b0)
                    : (r.addr[ADDR_W-1] == `SFP_TOP_HALF);
                default: h = 1'b0;
            endcase
        end
        return h;
    endfunction : f_hit

    assign prot_hit = f_hit(prot_r, i_pe);

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shreg_nxt = shreg_r;
        opc_nxt = opc_r;
        bit_nxt = bit_r;
        so_nxt = so_r;
        oe_n_nxt = oe_n_r;
        held_nxt = held_r;
        busy_nxt = busy_r;
        wel_nxt = wel_r;
        prot_nxt = prot_r;
        nv_wr_nxt = 1'b0;
        go_nxt = 1'b0;
        ref_nxt = 1'b0;
        // latch clears when the engine finishes
        if (i_pe_done) begin
            busy_nxt = 1'b0;
            wel_nxt = 1'b0;
        end
        // refuse without latch or into protection
        if (i_pe_req) begin
            if (busy_r || !wel_r || prot_hit) begin
                ref_nxt = 1'b1;
            end else begin
                go_nxt = 1'b1;
                busy_nxt = 1'b1;
            end
        end
        // select rise ends any sequence, paused or not
        if (sel_rise) begin
            // Commands act only when complete with no extra clock
            if (state_r == ST_SKIP && cnt_r == `SFP_CNT_ZERO && !held_r && !busy_r) begin
                case (opc_r)
                    `SFP_OP_WRITE_ENABLE_CMD: wel_nxt = 1'b1;
                    `SFP_OP_WRITE_DISABLE_CMD: wel_nxt = 1'b0;
                    `SFP_OP_STATUS_WRITE_CMD: begin
                        // lock applies only with pin low
                        if (wel_r && !(prot_r.lock && !filt[`SFP_PIN_WP])) begin
                            // new bits go to the store
                            prot_nxt.lock = shreg_r[`SFP_ST_LOCK];
                            prot_nxt.bottom = shreg_r[`SFP_ST_BOT];
                            prot_nxt.lvl_hi = shreg_r[`SFP_ST_HI];
                            prot_nxt.lvl_mid = shreg_r[`SFP_ST_MID];
                            prot_nxt.lvl_lo = shreg_r[`SFP_ST_LO];
                            nv_wr_nxt = 1'b1;
                            wel_nxt = 1'b0;
                        end
                    end
                    default: begin
                        // Other opcodes belong to the main decoder
                    end
                endcase
            end
            state_nxt = ST_IDLE;
            held_nxt = 1'b0;
            oe_n_nxt = 1'b1;
        end else if (sel_fall) begin
            state_nxt = ST_OPC;
            cnt_nxt = `SFP_CNT_ZERO;
        end else if (held_r) begin
            // resume in place; otherwise stay paused
            if (hold_rise && sck_lo) begin
                held_nxt = 1'b0;
                oe_n_nxt = (state_r != ST_RDSR);
            end
        end else if (state_r != ST_IDLE) begin
            // pause only when clock is low
            if (hold_fall && sck_lo) begin
                held_nxt = 1'b1;
                oe_n_nxt = 1'b1;
            end else if (sck_rise) begin
                case (state_r)
                    ST_OPC: begin
                        shreg_nxt = {shreg_r[6:0], filt[`SFP_PIN_SI]};
                        cnt_nxt = cnt_r + `SFP_CNT_ONE;
                        if (cnt_r == `SFP_CNT_LAST) begin
                            opc_nxt = shreg_nxt;
                            cnt_nxt = `SFP_CNT_ZERO;
                            // status write takes one data byte
                            if (shreg_nxt == `SFP_OP_STATUS_WRITE_CMD) begin
                                state_nxt = ST_WDATA;
                            end else if (shreg_nxt == `SFP_OP_RDSR) begin
                                state_nxt = ST_RDSR;
                                bit_nxt = `SFP_CNT_LAST;
                                oe_n_nxt = 1'b0;
                            end else begin
                                state_nxt = ST_SKIP;
                            end
                        end
                    end
                    ST_WDATA: begin
                        shreg_nxt = {shreg_r[6:0], filt[`SFP_PIN_SI]};
                        cnt_nxt = cnt_r + `SFP_CNT_ONE;
                        if (cnt_r == `SFP_CNT_LAST) begin
                            cnt_nxt = `SFP_CNT_ZERO;
                            state_nxt = ST_SKIP;
                        end
                    end
                    // Extra clocks void a finished command
                    ST_SKIP: cnt_nxt = `SFP_CNT_ONE;
                    default: begin
                        // Status read ignores input
                    end
                endcase
            end else if (sck_fall && state_r == ST_RDSR) begin
                // Status repeats MSB first for as long as clocked
                so_nxt = st[bit_r];
                bit_nxt = bit_r - `SFP_CNT_ONE;
            end
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    // Protection bits reload from the store during reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            shreg_r <= '0;
            opc_r <= '0;
            bit_r <= '0;
            so_r <= 1'b0;
            oe_n_r <= 1'b1;
            held_r <= 1'b0;
            busy_r <= 1'b0;
            wel_r <= 1'b0;
            prot_r <= i_nv_prot;
            nv_wr_r <= 1'b0;
            go_r <= 1'b0;
            ref_r <= 1'b0;
            prev_r <= PIN_RST;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shreg_r <= shreg_nxt;
            opc_r <= opc_nxt;
            bit_r <= bit_nxt;
            so_r <= so_nxt;
            oe_n_r <= oe_n_nxt;
            held_r <= held_nxt;
            busy_r <= busy_nxt;
            wel_r <= wel_nxt;
            prot_r <= prot_nxt;
            nv_wr_r <= nv_wr_nxt;
            go_r <= go_nxt;
            ref_r <= ref_nxt;
            prev_r <= filt;
        end
    end

    assign o_so = so_r;
    assign o_so_oe_n = oe_n_r;
    assign o_held = held_r;
    assign o_status = st;
    assign o_nv_prot = prot_r;
    assign o_nv_wr = nv_wr_r;
    assign o_pe_go = go_r;
    assign o_pe_refuse = ref_r;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_hold_enter;
        !held_r && state_r != ST_IDLE && !sel_rise && hold_fall && sck_lo |=> held_r ##1 o_so_oe_n;
    endproperty
    a_hold_enter: assert property (p_hold_enter) else $error("pause not entered");
    property p_hold_exit;
        held_r && !sel_rise && hold_rise && sck_lo |=> !held_r && $stable(state_r) && $stable(cnt_r);
    endproperty
    a_hold_exit: assert property (p_hold_exit) else $error("pause not left in place");
    property p_hold_freeze;
        held_r && !sel_rise && !(hold_rise && sck_lo) |=> o_so_oe_n && $stable(shreg_r) && $stable(cnt_r)
            && $stable(o_so);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("pins not ignored in pause");
    property p_abort;
        sel_rise |=> state_r == ST_IDLE && !held_r && o_so_oe_n;
    endproperty
    a_abort: assert property (p_abort) else $error("select rise did not abort");
    property p_hold_keep;
        held_r && !filt[`SFP_PIN_HOLD] && !sel_rise |=> held_r;
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("pause dropped early");
    property p_locked;
        sel_rise && opc_r == `SFP_OP_STATUS_WRITE_CMD && prot_r.lock && !filt[`SFP_PIN_WP] |=> $stable(prot_r) && !o_nv_wr;
    endproperty
    a_locked: assert property (p_locked) else $error("locked bits changed");
    property p_unlocked;
        sel_rise && state_r == ST_SKIP && cnt_r == `SFP_CNT_ZERO && !held_r && !busy_r && opc_r == `SFP_OP_STATUS_WRITE_CMD
            && wel_r && filt[`SFP_PIN_WP] |=> o_nv_wr && !wel_r && o_nv_prot.lock == $past(shreg_r[`SFP_ST_LOCK]);
    endproperty
    a_unlocked: assert property (p_unlocked) else $error("status write not done");
    property p_refuse;
        i_pe_req && !busy_r && (!wel_r || prot_hit) |=> o_pe_refuse && !o_pe_go && !busy_r;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad write not refused");
    property p_go;
        o_pe_go |-> $past(wel_r) && o_status.busy && !$past(busy_r);
    endproperty
    a_go: assert property (p_go) else $error("go without latch");
    property p_done;
        i_pe_done && !i_pe_req |=> !o_status.write_latch && !o_status.busy;
    endproperty
    a_done: assert property (p_done) else $error("latch not cleared");
    property p_chip;
        i_pe_req && i_pe.kind == PE_CHIP && (prot_r.bottom || prot_r.lvl_lo) |=> o_pe_refuse;
    endproperty
    a_chip: assert property (p_chip) else $error("chip erase not refused");
    property p_spare;
        o_status.spare == 1'b0;
    endproperty
    a_spare: assert property (p_spare) else $error("spare bit set");

    c_hold: cover property (hold_fall && sck_lo && state_r != ST_IDLE ##1 held_r);
    c_status_write_cmd: cover property (o_nv_wr);
    c_go: cover property (o_pe_go);
    c_rdsr: cover property (state_r == ST_RDSR && !o_so_oe_n);

endmodule : sfp_hold_protect

`default_nettype wire

// ### bench/sfp_host_model.sv
// Host controller model that drives the flash pins for the bench.
// Assumes a 50 MHz bench clock; the link clock has a 160 ns period.
`timescale 1ns/1ps
`default_nettype none

module sfp_host_model (
    input wire logic i_clk, // Bench clock
    input wire logic i_so, // Device data out
    output logic o_sel_n, // Select, low
    output logic o_sck, // Link clock, still between frames
    output logic o_si, // Link data
    output logic o_hold_n, // Pause, low
    output logic o_wp_n // Lock enable, low
);
    // ************************************
    // Pin levels and frame tasks
    // ************************************
    // Pins start at the levels the device expects in reset
    initial begin
        o_sel_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_hold_n = 1'b1;
        o_wp_n = 1'b1;
    end
    // Step n clocks, then move off the edge
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : w
    task automatic start();
        o_sel_n = 1'b0;
        w(4);
    endtask : start
    // One link clock; data out is taken late in the high phase
    task automatic bitx(input logic b, output logic q);
        o_sck = 1'b0;
        o_si = b;
        w(4);
        o_sck = 1'b1;
        w(4);
        q = i_so;
    endtask : bitx
    // Released data line flips so a stale level is never trusted
    task automatic stop();
        o_sck = 1'b0;
        w(4);
        o_sel_n = 1'b1;
        o_si = ~o_si;
        w(8);
    endtask : stop
    // pause pin moves with clock low
    task automatic hold_set(input logic v);
        o_sck = 1'b0;
        w(4);
        o_hold_n = v;
        w(8);
    endtask : hold_set
    // Lock pin change, given time to pass the synchroniser
    task automatic set_wp(input logic v);
        o_wp_n = v;
        w(6);
    endtask : set_wp
    // Whole frame of n bits, MSB first; q keeps the last 8 bits read
    task automatic xfer(input logic [15:0] d, input int n, output logic [7:0] q);
        logic b;
        start();
        for (int i = 0; i < n; i++) begin
            bitx(d[15 - i], b);
            q = {q[6:0], b};
        end
        stop();
    endtask : xfer
endmodule : sfp_host_model

`default_nettype wire

// ### bench/tb_sfp_hold_protect.sv
// Self-checking bench for the pause and protection block.
// Assumes the host model on the pins and the bench as array engine.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_regs.svh"

module tb_sfp_hold_protect
    import sfp_pkg::*;
;
    logic clk, rst, sel_n, sck, si, hold_n, wp_n, so, so_oe_n, held;
    logic nv_wr, pe_req, pe_done, pe_go, pe_refuse;
    logic so_pin; // Data line as the host sees it; released shows the inverse
    assign so_pin = so_oe_n ? ~so : so;
    sfp_status_s status; // Status byte seen
    sfp_prot_s nv_in, nv_out; // Stored and current protection
    sfp_pe_s pe; // Request to the block
    int error_cnt = 0;
    int n_compared = 0;
    // Edge addresses of the eighth and half regions; the last slot goes with chip erase
    localparam logic [18:0] ADR [0:7] = '{19'h00000, 19'h0FFFF, 19'h10000, 19'h3FFFF,
        19'h40000, 19'h6FFFF, 19'h70000, 19'h7FFFF};

    sfp_hold_protect DUT (.i_clk(clk), .i_rst(rst), .i_sel_n(sel_n), .i_sck(sck), .i_si(si),
        .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe_n(so_oe_n), .o_held(held),
        .o_status(status), .i_nv_prot(nv_in), .o_nv_prot(nv_out), .o_nv_wr(nv_wr),
        .i_pe_req(pe_req), .i_pe(pe), .i_pe_done(pe_done), .o_pe_go(pe_go), .o_pe_refuse(pe_refuse));
    sfp_host_model host (.i_clk(clk), .i_so(so_pin), .o_sel_n(sel_n), .o_sck(sck), .o_si(si),
        .o_hold_n(hold_n), .o_wp_n(wp_n));

    // ************************************
    // Shared helpers
    // ************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    // Region model; a lock change cannot move these edges
    function automatic logic blocked(input sfp_prot_s p, input sfp_pe_e k, input logic [18:0] a);
        logic [19:0] sz;
        sz = 20'h08000 << {p.lvl_mid, p.lvl_lo};
        if (k == PE_CHIP) return |{p.bottom, p.lvl_hi, p.lvl_mid, p.lvl_lo};
        if (p.lvl_hi) return 1'b1;
        if (!(p.lvl_mid | p.lvl_lo)) return 1'b0;
        return p.bottom ? ({1'b0, a} < sz) : ({1'b0, a} >= 20'h80000 - sz);
    endfunction : blocked
    // write enable before each status write
    task automatic wr_status(input logic [7:0] d);
        logic [7:0] q;
        host.xfer({`SFP_OP_WRITE_ENABLE_CMD, 8'h00}, 8, q);
        host.xfer({`SFP_OP_STATUS_WRITE_CMD, d}, 16, q);
    endtask : wr_status
    // One request; an accepted one runs to completion
    // no serial traffic while busy
    task automatic pe_try(input sfp_pe_e k, input logic [18:0] a, input logic go);
        pe = '{kind: k, addr: a};
        pe_req = 1'b1;
        w(1);
        pe_req = 1'b0;
        chk({6'h00, pe_go, pe_refuse}, {6'h00, go, ~go});
        chk({7'h00, status.busy}, {7'h00, go});
        if (go) begin
            w(3);
            pe_done = 1'b1;
            w(1);
            pe_done = 1'b0;
            w(2);
            chk({6'h00, status.write_latch, status.busy}, 8'h00);
        end
    endtask : pe_try

    // ************************************
    // Scenarios
    // ************************************
    task automatic t_reset();
        chk(status, 8'h28);
        chk({3'h0, nv_out}, 8'h0A);
        chk({6'h00, held, so_oe_n}, 8'h01);
        pe_try(PE_PAGE, 19'h7FFFF, 1'b0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_hold();
        logic [7:0] q;
        logic b;
        host.start();
        for (int i = 0; i < 12; i++) begin
            host.bitx(i == 5 || i == 7, b);
            q = {q[6:0], b};
        end
        host.hold_set(1'b0);
        chk({6'h00, held, so_oe_n}, 8'h03);
        host.bitx(1'b1, b);
        host.bitx(1'b0, b);
        host.o_sck = 1'b0;
        host.w(8);
        chk({7'h00, held}, 8'h01);
        host.hold_set(1'b1);
        chk({6'h00, held, so_oe_n}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            host.bitx(1'b0, b);
            q = {q[6:0], b};
        end
        host.stop();
        chk(q, 8'h28);
        $display("hold test done");
    endtask : t_hold
    task automatic t_abort();
        logic [7:0] q;
        logic b;
        host.xfer({`SFP_OP_WRITE_ENABLE_CMD, 8'h00}, 8, q);
        chk({7'h00, status.write_latch}, 8'h01);
        host.xfer({`SFP_OP_WRITE_DISABLE_CMD, 8'h00}, 8, q);
        chk({7'h00, status.write_latch}, 8'h00);
        host.start();
        for (int i = 0; i < 8; i++) begin
            host.bitx(i == 5 || i == 6, b);
        end
        host.hold_set(1'b0);
        host.stop();
        host.hold_set(1'b1);
        chk({6'h00, held, status.write_latch}, 8'h00);
        host.xfer({`SFP_OP_RDSR, 8'h00}, 16, q);
        chk(q, 8'h28);
        $display("abort test done");
    endtask : t_abort
    task automatic t_lock();
        logic [7:0] q;
        host.set_wp(1'b0);
        wr_status(8'hA8);
        chk(status, 8'hA8);
        wr_status(8'h00);
        chk(status, 8'hAA);
        host.set_wp(1'b1);
        host.xfer({`SFP_OP_STATUS_WRITE_CMD, 8'h47}, 16, q);
        chk(status, 8'h04);
        host.set_wp(1'b0);
        $display("lock test done");
    endtask : t_lock
    // Every level and bottom-select code against the eighth and half region edges
    task automatic t_table();
        logic [7:0] q;
        sfp_prot_s p;
        sfp_pe_e k;
        for (int c = 0; c < 16; c++) begin
            p = '{lock: 1'b0, bottom: c[3], lvl_hi: c[2], lvl_mid: c[1], lvl_lo: c[0]};
            wr_status({2'b00, c[3:0], 2'b00});
            chk({3'h0, nv_out}, {3'h0, p});
            for (int i = 0; i < 8; i++) begin
                k = sfp_pe_e'(i == 7 ? 3 : i % 3);
                host.xfer({`SFP_OP_WRITE_ENABLE_CMD, 8'h00}, 8, q);
                pe_try(k, ADR[i], !blocked(p, k, ADR[i]));
            end
        end
        $display("protection table test done");
    endtask : t_table
    // Mid-run reset reloads other stored bits; lock then holds with pin low
    task automatic t_reload();
        rst = 1'b1;
        nv_in = 5'h15;
        w(2);
        rst = 1'b0;
        w(4);
        chk(status, 8'h94);
        chk({3'h0, nv_out}, 8'h15);
        chk({6'h00, held, so_oe_n}, 8'h01);
        wr_status(8'h00);
        chk(status, 8'h96);
        pe_try(PE_SECTOR, 19'h00000, 1'b0);
        $display("reload test done");
    endtask : t_reload

    // Sequence budget is about 16000 clocks; the watchdog allows two and a half times that
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        test_done();
    end
    initial begin
        rst = 1'b1;
        pe_req = 1'b0;
        pe_done = 1'b0;
        pe = '0;
        nv_in = 5'h0A;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        w(4);
        t_reset();
        t_hold();
        t_abort();
        t_lock();
        t_table();
        t_reload();
        test_done();
    end
endmodule : tb_sfp_hold_protect

`default_nettype wire
